// ---- ssap_top.sv ----
// ssap_top: slave serial audio port with an axi4-lite register slave.
// assumes: the audio master drives bit clock and frame sync; the bit clock
// may stop between frames; software sets the mode while the port is idle.
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
module ssap_top (
    // core clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // audio link pins
    input  wire logic        audio_bit_clock,
    input  wire logic        audio_frame_sync,
    input  wire logic        audio_data,
    // axi4-lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    // axi4-lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // axi4-lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // axi4-lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    // axi4-lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp
);

    // ------------------------------------------------------------
    // state of the core domain
    // ------------------------------------------------------------
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [9:0]  ctrl;
        logic        sample_valid;
        logic        overrun;
        logic [23:0] left;
        logic [23:0] right;
        logic [31:0] frames;
        logic        prev_toggle;
    } ssap_core_s;

    ssap_core_s  st_reg;
    ssap_core_s  st_next;
    logic [5:0]  cfg_link;
    logic [23:0] link_left;
    logic [23:0] link_right;
    logic        link_toggle;
    logic        cfg_enable_link;
    logic        toggle_sync;
    logic        new_frame;
    logic        do_write;
    logic        do_read;
    logic        stat_clear_valid;
    logic        stat_clear_ovr;
    logic [31:0] rd_word;
    logic [1:0]  rd_resp;

    // ------------------------------------------------------------
    // settings into the bit-clock domain
    // ------------------------------------------------------------
    // quasi-static levels, so per-bit synchronising is safe while idle
    ssap_sync2 #(
        .WIDTH (6)
    ) u_cfg_sync (
        .clock     (audio_bit_clock),
        .rst_b     (rst_b),
        .level_in  ({st_reg.ctrl[ssap_pkg::CTRL_DLY_BIT],
                     st_reg.ctrl[ssap_pkg::CTRL_WS_LSB +: 2],
                     st_reg.ctrl[ssap_pkg::CTRL_EDGE_BIT],
                     st_reg.ctrl[ssap_pkg::CTRL_FMT_LSB +: 2]}),
        .level_out (cfg_link)
    );

    ssap_link_rx u_link_rx (
        .audio_bit_clock  (audio_bit_clock),
        .rst_b            (rst_b),
        .audio_frame_sync (audio_frame_sync),
        .audio_data       (audio_data),
        .cfg_enable       (cfg_enable_link),
        .cfg_format       (cfg_link[1:0]),
        .cfg_edge_fall    (cfg_link[2]),
        .cfg_word_size    (cfg_link[4:3]),
        .cfg_dsp_second   (cfg_link[5]),
        .left_word        (link_left),
        .right_word       (link_right),
        .frame_toggle     (link_toggle)
    );

    // enable crosses on its own synchroniser
    ssap_sync2 #(
        .WIDTH (1)
    ) u_en_sync (
        .clock     (audio_bit_clock),
        .rst_b     (rst_b),
        .level_in  (st_reg.ctrl[ssap_pkg::CTRL_EN_BIT]),
        .level_out (cfg_enable_link)
    );

    // ------------------------------------------------------------
    // frame event back into the core domain
    // ------------------------------------------------------------
    // toggle handshake: the right word is held for a whole frame and the left word until the next left word ends, far longer
    // than the two core cycles the toggle needs to cross
    ssap_sync2 #(
        .WIDTH (1)
    ) u_tog_sync (
        .clock     (clock),
        .rst_b     (rst_b),
        .level_in  (link_toggle),
        .level_out (toggle_sync)
    );

    assign new_frame = toggle_sync != st_reg.prev_toggle;

    // ------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------
    always_comb begin
        rd_word = 32'h00000000;
        rd_resp = ssap_pkg::RESP_OKAY;
        if (s_axi_araddr == ssap_pkg::CTRL_OFS) begin
            rd_word = {22'h000000, st_reg.ctrl};
        end else if (s_axi_araddr == ssap_pkg::STAT_OFS) begin
            rd_word[ssap_pkg::STAT_VALID_BIT] = st_reg.sample_valid;
            rd_word[ssap_pkg::STAT_OVR_BIT]   = st_reg.overrun;
        end else if (s_axi_araddr == ssap_pkg::LEFT_OFS) begin
            rd_word = {8'h00, st_reg.left};
        end else if (s_axi_araddr == ssap_pkg::RIGHT_OFS) begin
            rd_word = {8'h00, st_reg.right};
        end else if (s_axi_araddr == ssap_pkg::FRAMES_OFS) begin
            rd_word = st_reg.frames;
        end else begin
            rd_resp = ssap_pkg::RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------
    // bus slave and register file
    // ------------------------------------------------------------
    // address and data may arrive in either order; the write lands
    // once both are held and no response is pending
    always_comb begin
        st_next = st_reg;
        do_write = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
        do_read  = s_axi_arvalid && st_reg.arready;
        stat_clear_valid = 1'b0;
        stat_clear_ovr   = 1'b0;
        if (s_axi_awvalid && st_reg.awready) begin
            st_next.aw_held = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_reg.wready) begin
            st_next.w_held = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            st_next.aw_held = 1'b0;
            st_next.w_held  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = ssap_pkg::RESP_OKAY;
            if (st_reg.aw_addr == ssap_pkg::CTRL_OFS) begin
                if (st_reg.w_strb[0]) begin
                    st_next.ctrl[7:0] = st_reg.w_data[7:0];
                end
                if (st_reg.w_strb[1]) begin
                    st_next.ctrl[9:8] = st_reg.w_data[9:8];
                end
            end else if (st_reg.aw_addr == ssap_pkg::STAT_OFS) begin
                // write one to clear
                stat_clear_valid = st_reg.w_strb[0]
                                   && st_reg.w_data[ssap_pkg::STAT_VALID_BIT];
                stat_clear_ovr   = st_reg.w_strb[0]
                                   && st_reg.w_data[ssap_pkg::STAT_OVR_BIT];
            end else if (st_reg.aw_addr == ssap_pkg::LEFT_OFS
                         || st_reg.aw_addr == ssap_pkg::RIGHT_OFS
                         || st_reg.aw_addr == ssap_pkg::FRAMES_OFS) begin
                st_next.bresp = ssap_pkg::RESP_OKAY;
            end else begin
                st_next.bresp = ssap_pkg::RESP_SLVERR;
            end
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        // ready only while nothing of that kind is held or answered
        st_next.awready = !st_next.aw_held && !st_next.bvalid
                          && !(s_axi_awvalid && st_reg.awready);
        st_next.wready  = !st_next.w_held && !st_next.bvalid
                          && !(s_axi_wvalid && st_reg.wready);
        if (do_read) begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = rd_word;
            st_next.rresp  = rd_resp;
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        st_next.arready = !st_next.rvalid && !do_read;

        // status flags: a new frame wins over a clear in the same cycle
        st_next.prev_toggle = toggle_sync;
        if (stat_clear_valid) begin
            st_next.sample_valid = 1'b0;
        end
        if (stat_clear_ovr) begin
            st_next.overrun = 1'b0;
        end
        if (new_frame) begin
            st_next.left         = link_left;
            st_next.right        = link_right;
            st_next.frames       = st_reg.frames + 32'h00000001;
            st_next.sample_valid = 1'b1;
            if (st_reg.sample_valid && !stat_clear_valid) begin
                st_next.overrun = 1'b1;
            end
        end
    end

    // settings only change through software writes
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_reg         <= '0;
            st_reg.awready <= 1'b1;
            st_reg.wready  <= 1'b1;
            st_reg.arready <= 1'b1;
            st_reg.ctrl    <= ssap_pkg::CTRL_RESET;
            st_reg.frames  <= ssap_pkg::FRAMES_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state flops
    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready  = st_reg.wready;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;

endmodule : ssap_top

// ---- ssap_pkg.sv ----
// ssap_pkg: register map, field positions, reset values and mode
// encodings for the slave serial audio port.
// assumes: shared by the core-side top and the bit-clock-side receiver.
package ssap_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STAT_OFS   = 8'h04;
    localparam logic [7:0] LEFT_OFS   = 8'h08;
    localparam logic [7:0] RIGHT_OFS  = 8'h0c;
    localparam logic [7:0] FRAMES_OFS = 8'h10;

    // ------------------------------------------------------------
    // control and status field positions
    // ------------------------------------------------------------
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_FMT_LSB  = 1;
    localparam int CTRL_EDGE_BIT = 3;
    localparam int CTRL_WS_LSB   = 4;
    localparam int CTRL_DLY_BIT  = 6;
    localparam int CTRL_RATE_LSB = 8;
    localparam int STAT_VALID_BIT = 0;
    localparam int STAT_OVR_BIT   = 1;

    // ------------------------------------------------------------
    // reset values and bus answers
    // ------------------------------------------------------------
    localparam logic [9:0]  CTRL_RESET   = 10'h000;
    localparam logic [23:0] WORD_RESET   = 24'h000000;
    localparam logic [31:0] FRAMES_RESET = 32'h00000000;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // ------------------------------------------------------------
    // word lengths in bits and msb delays in bit-clock edges
    // ------------------------------------------------------------
    localparam logic [4:0] WLEN_8  = 5'h08;
    localparam logic [4:0] WLEN_16 = 5'h10;
    localparam logic [4:0] WLEN_20 = 5'h14;
    localparam logic [4:0] WLEN_24 = 5'h18;
    localparam logic [1:0] DLY_FIRST  = 2'h0;
    localparam logic [1:0] DLY_SECOND = 2'h1;
    localparam logic [1:0] DLY_THIRD  = 2'h2;

    // ------------------------------------------------------------
    // mode encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {FMT_I2S, FMT_LJ, FMT_DSP, FMT_RSVD} ssap_fmt_e;
    typedef enum logic [1:0] {WS_8, WS_16, WS_20, WS_24} ssap_ws_e;
    typedef enum logic [1:0] {RATE_32K, RATE_40K, RATE_44K1, RATE_48K} ssap_rate_e;

endpackage : ssap_pkg

// ---- ssap_sync2.sv ----
// ssap_sync2: two-flop synchroniser for quasi-static levels.
// assumes: each bit is a level that holds for many destination clocks.
module ssap_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset of the destination domain
    input  wire logic             clock,
    input  wire logic             rst_b,
    // level in and synchronised level out
    input  wire logic [WIDTH-1:0] level_in,
    output logic      [WIDTH-1:0] level_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } ssap_sync_s;

    ssap_sync_s state_reg;
    ssap_sync_s state_next;

    // first stage feeds only the second stage
    always_comb begin
        state_next.meta   = level_in;
        state_next.stable = state_reg.meta;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign level_out = state_reg.stable;

endmodule : ssap_sync2

// ---- ssap_link_rx.sv ----
// ssap_link_rx: bit-clock-domain receiver that frames and deserialises
// stereo words from the data line.
// assumes: settings are static during frames; pins are timed by the bit clock.
module ssap_link_rx (
    // link clock and reset
    input  wire logic        audio_bit_clock,
    input  wire logic        rst_b,
    // link pins
    input  wire logic        audio_frame_sync,
    input  wire logic        audio_data,
    // settings, already synchronised to the bit clock
    input  wire logic        cfg_enable,
    input  wire logic [1:0]  cfg_format,
    input  wire logic        cfg_edge_fall,
    input  wire logic [1:0]  cfg_word_size,
    input  wire logic        cfg_dsp_second,
    // completed frame, right word stable while toggle is unchanged, left word updated mid-frame
    output logic [23:0]      left_word,
    output logic [23:0]      right_word,
    output logic             frame_toggle
);

    typedef struct packed {
        logic        busy;
        logic [1:0]  dly;
        logic [4:0]  bits;
        logic        right_chan;
        logic [23:0] shreg;
        logic [23:0] left;
        logic [23:0] right;
        logic        prev_fs;
        logic        toggle;
    } ssap_rx_s;

    ssap_rx_s   st_reg;
    ssap_rx_s   st_next;
    logic       neg_data_reg;
    logic       neg_fs_reg;
    logic       smp_data;
    logic       smp_fs;
    logic       start;
    logic [4:0] wlen;
    logic [1:0] dly_v;
    logic [23:0] word_v;

    // falling-edge copies of the pins, offered to the rising-edge logic
    always_ff @(negedge audio_bit_clock or negedge rst_b) begin
        if (!rst_b) begin
            neg_data_reg <= 1'b0;
            neg_fs_reg   <= 1'b0;
        end else begin
            neg_data_reg <= audio_data;
            neg_fs_reg   <= audio_frame_sync;
        end
    end

    // framing and shift register
    always_comb begin
        st_next = st_reg;
        smp_data = cfg_edge_fall ? neg_data_reg : audio_data;
        smp_fs   = cfg_edge_fall ? neg_fs_reg : audio_frame_sync;
        case (ssap_pkg::ssap_ws_e'(cfg_word_size))
            ssap_pkg::WS_8:  wlen = ssap_pkg::WLEN_8;
            ssap_pkg::WS_16: wlen = ssap_pkg::WLEN_16;
            ssap_pkg::WS_20: wlen = ssap_pkg::WLEN_20;
            default:         wlen = ssap_pkg::WLEN_24;
        endcase
        start  = 1'b0;
        dly_v  = ssap_pkg::DLY_FIRST;
        word_v = {st_reg.shreg[22:0], smp_data};
        st_next.prev_fs = smp_fs;
        // framing only from the external sync
        if (cfg_enable) begin
            case (ssap_pkg::ssap_fmt_e'(cfg_format))
                ssap_pkg::FMT_I2S: begin
                    // msb on second edge after a transition
                    start = smp_fs != st_reg.prev_fs;
                    dly_v = ssap_pkg::DLY_SECOND;
                    st_next.right_chan = start ? smp_fs : st_reg.right_chan;
                end
                ssap_pkg::FMT_LJ: begin
                    // msb on first edge after a transition
                    start = smp_fs != st_reg.prev_fs;
                    dly_v = ssap_pkg::DLY_FIRST;
                    st_next.right_chan = start ? !smp_fs : st_reg.right_chan;
                end
                ssap_pkg::FMT_DSP: begin
                    start = smp_fs && !st_reg.prev_fs;
                    // first or second edge after the pulse
                    dly_v = cfg_dsp_second ? ssap_pkg::DLY_THIRD : ssap_pkg::DLY_SECOND;
                    st_next.right_chan = start ? 1'b0 : st_reg.right_chan;
                end
                default: begin
                    start = 1'b0;
                end
            endcase
        end
        if (start) begin
            st_next.busy  = 1'b1;
            st_next.dly   = dly_v;
            st_next.bits  = 5'h00;
            st_next.shreg = ssap_pkg::WORD_RESET;
            word_v        = {23'h000000, smp_data};
        end
        if (st_next.busy && cfg_enable) begin
            if (st_next.dly != ssap_pkg::DLY_FIRST) begin
                st_next.dly = st_next.dly - 2'h1;
            end else begin
                st_next.shreg = word_v;
                st_next.bits  = st_next.bits + 5'h01;
                if (st_next.bits == wlen) begin
                    // bits after the lsb are ignored
                    st_next.busy = 1'b0;
                    if (st_next.right_chan) begin
                        st_next.right  = word_v;
                        st_next.toggle = !st_reg.toggle;
                    end else begin
                        st_next.left = word_v;
                    end
                    // right word follows at once in dsp mode
                    if (cfg_format == ssap_pkg::FMT_DSP && !st_next.right_chan) begin
                        st_next.busy       = 1'b1;
                        st_next.right_chan = 1'b1;
                        st_next.bits       = 5'h00;
                        st_next.shreg      = ssap_pkg::WORD_RESET;
                    end
                end
            end
        end
        if (!cfg_enable) begin
            st_next.busy = 1'b0;
        end
    end

    always_ff @(posedge audio_bit_clock or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign left_word    = st_reg.left;
    assign right_word   = st_reg.right;
    assign frame_toggle = st_reg.toggle;

endmodule : ssap_link_rx

// ---- ssap_checker.sv ----
// ssap_checker: register bus assertions for the audio port
// assumes: bound onto ssap_top and sees only its ports
module ssap_checker (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst_b,
    // bus handshakes and answers
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    // settings writes answer within three cycles
    write_answer_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("refused read carries data");
endmodule : ssap_checker

bind ssap_top ssap_checker chk (.clock, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

// ---- ssap_audio_master.sv ----
// ssap_audio_master: behavioural audio master driving the link pins
// assumes: bit clock idles low between frames, period 125 ns
module ssap_audio_master (
    // link pins
    output logic audio_bit_clock,
    output logic audio_frame_sync,
    output logic audio_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic fall_cap = 1'b0;
    initial begin
        audio_bit_clock = 1'b0;
        audio_frame_sync = 1'b0;
        audio_data = 1'b0;
    end
    // pins change away from the capture edge
    task automatic slot(input logic fs, input logic d);
        if (!fall_cap)
            {audio_frame_sync, audio_data} = {fs, d};
        #62.5 audio_bit_clock = 1'b1;
        if (fall_cap)
            {audio_frame_sync, audio_data} = {fs, d};
        #62.5 audio_bit_clock = 1'b0;
    endtask : slot
    task automatic word(input logic fs, input logic [23:0] w, input int n);
        for (int i = n - 1; i >= 0; i--)
            slot(fs, w[i]);
    endtask : word
    // spare bits carry the inverse of their neighbour
    task automatic frame(input logic [1:0] fmt, input int n, input logic dly2, fall,
                         input logic [23:0] l, r);
        fall_cap = fall;
        repeat (4) slot(1'b0, ~l[n-1]);
        case (fmt)
            // left while sync low, msb one bit late
            2'h0: begin
                slot(1'b1, ~l[n-1]);
                slot(1'b0, ~l[n-1]);
                word(1'b0, l, n);
                slot(1'b0, ~l[0]);
                slot(1'b1, ~r[n-1]);
                word(1'b1, r, n);
            end
            2'h1: begin
                word(1'b1, l, n);
                slot(1'b1, ~l[0]);
                word(1'b0, r, n);
            end
            // one-period pulse, words back to back
            default: begin
                slot(1'b1, ~l[n-1]);
                if (dly2)
                    slot(1'b0, ~l[n-1]);
                word(1'b0, l, n);
                word(1'b0, r, n);
            end
        endcase
        slot(audio_frame_sync, ~r[0]);
    endtask : frame
endmodule : ssap_audio_master

// ---- test_slave_serial_audio_port.sv ----
// test_slave_serial_audio_port: register and link scenarios for ssap_top
// assumes: ssap_audio_master times the link; checker bound separately
module test_slave_serial_audio_port;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0, rst_b = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic audio_bit_clock, audio_frame_sync, audio_data;
    int err_count = 0, comparisons = 0, cycles = 0;
    logic [1:0] fm [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
    logic [1:0] ws [5] = '{2'h1, 2'h0, 2'h3, 2'h1, 2'h2};
    logic dly [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    logic edg [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    int nb [5] = '{16, 8, 24, 16, 20};
    always #5 clock = ~clock;
    ssap_audio_master master (.audio_bit_clock, .audio_frame_sync, .audio_data);
    ssap_top dut (.clock, .rst_b, .audio_bit_clock, .audio_frame_sync, .audio_data,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp);
    task automatic conclude;
        if (err_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic check(input string name, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // bready stands with the request until bvalid is sampled
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        @(posedge clock);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
        do begin
            @(posedge clock);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check("bresp", {30'h0, s_axi_bresp}, {30'h0, resp});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        @(posedge clock);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do begin
            @(posedge clock);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check("rdata", s_axi_rdata, d);
        check("rresp", {30'h0, s_axi_rresp}, {30'h0, resp});
    endtask : rd
    task automatic t_registers;
        rd(ssap_pkg::CTRL_OFS, 32'h0, ssap_pkg::RESP_OKAY);
        wr(8'h14, 32'hffffffff, ssap_pkg::RESP_SLVERR);
        rd(8'h14, 32'h0, ssap_pkg::RESP_SLVERR);
        wr(ssap_pkg::LEFT_OFS, 32'hffffffff, ssap_pkg::RESP_OKAY);
        rd(ssap_pkg::LEFT_OFS, 32'h0, ssap_pkg::RESP_OKAY);
    endtask : t_registers
    // every format but the reserved one, and every size, edge, delay and rate code, at least once
    task automatic t_frames;
        logic [31:0] ctrl;
        logic [23:0] l, r;
        for (int i = 0; i < 5; i++) begin
            ctrl = {22'h0, i[1:0], 1'b0, dly[i], ws[i], edg[i], fm[i], 1'b1};
            l = 24'ha5c3e1 & (24'hffffff >> (24 - nb[i]));
            r = 24'h5a3c1e & (24'hffffff >> (24 - nb[i]));
            wr(ssap_pkg::CTRL_OFS, ctrl, ssap_pkg::RESP_OKAY);
            rd(ssap_pkg::CTRL_OFS, ctrl, ssap_pkg::RESP_OKAY);
            master.frame(fm[i], nb[i], dly[i], edg[i], l, r);
            repeat (10) @(posedge clock);
            rd(ssap_pkg::LEFT_OFS, {8'h0, l}, ssap_pkg::RESP_OKAY);
            rd(ssap_pkg::RIGHT_OFS, {8'h0, r}, ssap_pkg::RESP_OKAY);
            rd(ssap_pkg::STAT_OFS, 32'h1, ssap_pkg::RESP_OKAY);
            wr(ssap_pkg::STAT_OFS, 32'h3, ssap_pkg::RESP_OKAY);
        end
    endtask : t_frames
    // a disabled port keeps the last words
    task automatic t_disabled;
        wr(ssap_pkg::CTRL_OFS, 32'h32, ssap_pkg::RESP_OKAY);
        master.frame(2'h1, 24, 1'b0, 1'b0, 24'h123456, 24'h654321);
        repeat (10) @(posedge clock);
        rd(ssap_pkg::LEFT_OFS, 32'h0005c3e1, ssap_pkg::RESP_OKAY);
        rd(ssap_pkg::STAT_OFS, 32'h0, ssap_pkg::RESP_OKAY);
        rd(ssap_pkg::FRAMES_OFS, 32'h5, ssap_pkg::RESP_OKAY);
    endtask : t_disabled
    // a hang ends the run through the same report
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        t_registers();
        t_frames();
        t_disabled();
        conclude();
    end
endmodule : test_slave_serial_audio_port
